/* File: design/sync_sram_pkg.sv */
package sync_sram_pkg;

  localparam int ADDR_W      = 14;
  localparam int LANE_W      = 9;
  localparam int LANES       = 2;
  localparam int WORD_W      = LANE_W * LANES;
  localparam int DEPTH       = 16384;
  localparam int DATA_W      = 16;
  localparam int LOW_PAR_BIT = 16;
  localparam int HIGH_PAR_BIT = 17;

  // Operation chosen by the registered controls
  typedef enum logic [3:0] {
    OP_DESEL = 4'b0001,
    OP_READ  = 4'b0010,
    OP_WRITE = 4'b0100,
    OP_ABORT = 4'b1000
  } op_t;

  // Pins sampled on the rising edge
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              write_n;
    logic              cs_hi;
    logic              cs_n;
  } sync_in_t;

  // Asynchronous-side controls
  typedef struct packed {
    logic low_strobe_n;
    logic high_strobe_n;
    logic latch_ctl;
    logic drive_en_n;
  } async_in_t;

endpackage : sync_sram_pkg

/* File: design/sram_array.sv */
`timescale 1ns/1ps
module sram_array
  import sync_sram_pkg::*;
#(
  parameter int AW    = ADDR_W,
  parameter int LW    = LANE_W,
  parameter int NL    = LANES,
  parameter int WORDS = DEPTH
) (
  // Clock
  input  wire logic             mclk_i,
  // Access
  input  wire logic [AW-1:0]    addr_i,
  input  wire logic [NL-1:0]    lane_we_i,
  input  wire logic [NL*LW-1:0] wdata_i,
  output logic      [NL*LW-1:0] rdata_o
);

  // One memory per lane so each lane has a single writer
  genvar g;
  generate
    for (g = 0; g < NL; g++) begin : g_lane
      logic [LW-1:0] lane_mem [WORDS];
      always_ff @(posedge mclk_i) begin
        if (lane_we_i[g]) begin
          lane_mem[addr_i] <= wdata_i[g*LW +: LW];
        end
        rdata_o[g*LW +: LW] <= lane_mem[addr_i];
      end
    end
  endgenerate

endmodule : sram_array

/* File: design/registered_input_sync_sram.sv */
`timescale 1ns/1ps
module registered_input_sync_sram
  import sync_sram_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 srst_i,
  // Registered controls
  input  wire logic [ADDR_W-1:0]    word_address_inputs_i,
  input  wire logic                 registered_write_select_n_i,
  input  wire logic                 registered_chip_select_hi_i,
  input  wire logic                 registered_chip_select_n_i,
  // Asynchronous controls
  input  wire logic                 low_byte_write_strobe_n_i,
  input  wire logic                 high_byte_write_strobe_n_i,
  input  wire logic                 input_latch_control_i,
  input  wire logic                 output_drive_enable_n_i,
  // Data pins
  input  wire logic [DATA_W-1:0]    data_lines_i,
  input  wire logic                 low_lane_parity_line_i,
  input  wire logic                 high_lane_parity_line_i,
  output logic      [DATA_W-1:0]    data_lines_o,
  output logic                      low_lane_parity_line_o,
  output logic                      high_lane_parity_line_o,
  output logic      [WORD_W-1:0]    data_lines_oe_o
);

  typedef struct packed {
    sync_in_t          cap;
    logic              cap_valid;
    logic              latch_prev;
    logic [WORD_W-1:0] held;
    op_t               op;
    logic              read_valid;
  } state_t;

  state_t            st;
  state_t            next_st;
  sync_in_t          pins;
  async_in_t         actl;
  logic [WORD_W-1:0] pin_word;
  logic [WORD_W-1:0] wr_word;
  logic [LANES-1:0]  lane_we;
  logic [WORD_W-1:0] arr_wdata;
  logic [WORD_W-1:0] arr_rdata;
  logic              selected;
  logic              latch_fall;

  assign pins     = '{addr: word_address_inputs_i, write_n: registered_write_select_n_i,
                      cs_hi: registered_chip_select_hi_i, cs_n: registered_chip_select_n_i};
  assign actl     = '{low_strobe_n: low_byte_write_strobe_n_i, high_strobe_n: high_byte_write_strobe_n_i,
                      latch_ctl: input_latch_control_i, drive_en_n: output_drive_enable_n_i};
  // Parity bits are just two more stored bits
  assign pin_word = {high_lane_parity_line_i, low_lane_parity_line_i, data_lines_i};

  // Transparent while high, otherwise the word caught at the first rising clock edge after it falls
  // A fall seen at this edge must still write the pin word being caught
  assign latch_fall = st.latch_prev && !actl.latch_ctl;
  assign wr_word    = (actl.latch_ctl || latch_fall) ? pin_word : st.held;

  assign selected = st.cap_valid && st.cap.cs_hi && !st.cap.cs_n;

  always_comb begin
    next_st            = st;
    next_st.cap        = pins;
    next_st.cap_valid  = 1'b1;
    next_st.latch_prev = actl.latch_ctl;
    next_st.read_valid = selected && (st.op == OP_READ);
    if (latch_fall) begin
      next_st.held = pin_word;
    end
    if (!(pins.cs_hi && !pins.cs_n)) begin
      next_st.op = OP_DESEL;
    end else if (pins.write_n) begin
      next_st.op = OP_READ;
    end else begin
      next_st.op = OP_WRITE;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st <= '{cap: '0, cap_valid: 1'b0, latch_prev: 1'b1, held: '0, op: OP_DESEL, read_valid: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // Strobes sampled at the end of the write cycle; both high aborts it
  always_comb begin
    lane_we = '0;
    case (st.op)
      OP_WRITE: begin
        if (selected) begin
          lane_we[0] = !actl.low_strobe_n;
          lane_we[1] = !actl.high_strobe_n;
        end
      end
      OP_DESEL, OP_READ, OP_ABORT: lane_we = '0;
      default: lane_we = '0;
    endcase
  end

  sram_array #(
    .AW    (ADDR_W),
    .LW    (LANE_W),
    .NL    (LANES),
    .WORDS (DEPTH)
  ) u_array (
    .mclk_i    (mclk_i),
    .addr_i    (st.cap.addr),
    .lane_we_i (lane_we),
    .wdata_i   (arr_wdata),
    .rdata_o   (arr_rdata)
  );

  // Array lanes hold {parity, byte}; pin word keeps parity on top
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane_map
      assign arr_wdata[g*LANE_W +: LANE_W] = {wr_word[DATA_W+g], wr_word[g*(LANE_W-1) +: LANE_W-1]};
      assign data_lines_o[g*(LANE_W-1) +: LANE_W-1] = arr_rdata[g*LANE_W +: LANE_W-1];
    end
  endgenerate

  assign low_lane_parity_line_o  = arr_rdata[LANE_W-1];
  assign high_lane_parity_line_o = arr_rdata[WORD_W-1];
  // Floated during reset, deselect, writes and aborts
  assign data_lines_oe_o = {WORD_W{st.read_valid && !actl.drive_en_n}};

endmodule : registered_input_sync_sram

/* File: bench/sync_sram_assertions.sv */
`timescale 1ns/1ps
module sync_sram_assertions
  import sync_sram_pkg::*;
(
  input wire logic              mclk_i, srst_i, registered_write_select_n_i,
  input wire logic              registered_chip_select_hi_i, registered_chip_select_n_i,
  input wire logic              output_drive_enable_n_i,
  input wire logic [WORD_W-1:0] data_lines_oe_o
);
  logic              sel, en_n, r1, rd2;
  logic [WORD_W-1:0] oe;
  assign sel = registered_chip_select_hi_i && !registered_chip_select_n_i;
  assign en_n = output_drive_enable_n_i;
  assign oe = data_lines_oe_o;
  // Read captured two edges ago, clear of reset
  always_ff @(posedge mclk_i) begin
    r1  <= sel && registered_write_select_n_i && !srst_i;
    rd2 <= r1 && !srst_i;
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  property p_read_on; rd2 && !en_n |-> oe == '1; endproperty
  a_read_on: assert property (p_read_on) else $error("read not driven");
  property p_read_off; !rd2 |-> oe == '0; endproperty
  a_read_off: assert property (p_read_off) else $error("drive without read");
  property p_float_drive; en_n |-> oe == '0; endproperty
  a_float_drive: assert property (p_float_drive) else $error("drive while disabled");
  property p_desel; !$past(sel, 2) |-> oe == '0; endproperty
  a_desel: assert property (p_desel) else $error("drive when deselected");
  property p_write_float; !$past(registered_write_select_n_i, 2) |-> oe == '0; endproperty
  a_write_float: assert property (p_write_float) else $error("drive on write");
  property p_uniform; oe == '0 || oe == '1; endproperty
  a_uniform: assert property (p_uniform) else $error("enables differ");
  property p_rise; $rose(oe[0]) |-> !en_n && rd2; endproperty
  a_rise: assert property (p_rise) else $error("unexpected drive start");
  property p_reset_float; disable iff (1'b0) $past(srst_i) |-> oe == '0; endproperty
  a_reset_float: assert property (p_reset_float) else $error("drive after reset");
endmodule : sync_sram_assertions
bind registered_input_sync_sram sync_sram_assertions chk_u (.*);

/* File: bench/sram_host_model.sv */
`timescale 1ns/1ps
module sram_host_model
  import sync_sram_pkg::*;
(
  input  wire logic        mclk_i,
  output sync_in_t         s_o,
  output async_in_t        a_o,
  output logic [WORD_W-1:0] d_o
);
  initial begin
    s_o = {14'h0000, 1'h1, 1'h0, 1'h1};
    a_o = 4'hF;
    d_o = '0;
  end
  // Controls for one edge, then strobes and data in the following cycle; latched data goes out with the controls
  task automatic cyc(input logic w_n, sel, input logic [1:0] stn, input logic lat, oen,
                     input logic [ADDR_W-1:0] ad, input logic [WORD_W-1:0] wd);
    @(negedge mclk_i);
    s_o = {ad, w_n, sel, !sel};
    a_o.drive_en_n = oen;
    if (lat) begin
      d_o = wd;
      a_o.latch_ctl = 1'h0;
    end
    @(negedge mclk_i);
    s_o = {ad, 1'h1, 1'h0, 1'h1};
    {a_o.low_strobe_n, a_o.high_strobe_n} = stn;
    d_o = lat ? ~wd : wd;
    @(negedge mclk_i);
    {a_o.low_strobe_n, a_o.high_strobe_n} = 2'h3;
    a_o.latch_ctl = 1'h1;
    d_o = ~d_o;
  endtask : cyc
endmodule : sram_host_model

/* File: bench/registered_input_sync_sram_test.sv */
`timescale 1ns/1ps
module registered_input_sync_sram_test;
  import sync_sram_pkg::*;
  logic              mclk_i = 1'h0;
  logic              srst_i = 1'h1;
  sync_in_t          s;
  async_in_t         a;
  logic [WORD_W-1:0] d, q, oe;
  int                miscompares = 0;
  int                checked = 0;
  initial forever #5 mclk_i = ~mclk_i;
  sram_host_model host_u (.mclk_i(mclk_i), .s_o(s), .a_o(a), .d_o(d));
  registered_input_sync_sram dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .word_address_inputs_i(s.addr),
    .registered_write_select_n_i(s.write_n), .registered_chip_select_hi_i(s.cs_hi),
    .registered_chip_select_n_i(s.cs_n), .low_byte_write_strobe_n_i(a.low_strobe_n),
    .high_byte_write_strobe_n_i(a.high_strobe_n), .input_latch_control_i(a.latch_ctl),
    .output_drive_enable_n_i(a.drive_en_n), .data_lines_i(d[15:0]), .low_lane_parity_line_i(d[16]),
    .high_lane_parity_line_i(d[17]), .data_lines_o(q[15:0]), .low_lane_parity_line_o(q[16]),
    .high_lane_parity_line_o(q[17]), .data_lines_oe_o(oe));
  task automatic chk(input logic [WORD_W-1:0] g, e);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Read with both strobes low; pins carry the inverse of the expected word
  task automatic rd(input logic [ADDR_W-1:0] ad, input logic [WORD_W-1:0] e, input logic oen);
    host_u.cyc(1'h1, 1'h1, 2'h0, 1'h0, oen, ad, ~e);
    chk(oe, {WORD_W{!oen}});
    if (!oen) chk(q, e);
  endtask : rd
  task automatic wr(input logic sel, input logic [1:0] stn, input logic lat, input logic [ADDR_W-1:0] ad,
                    input logic [WORD_W-1:0] wd);
    host_u.cyc(1'h0, sel, stn, lat, 1'h0, ad, wd);
    chk(oe, '0);
  endtask : wr
  task automatic t_word;
    wr(1'h1, 2'h0, 1'h0, 14'h3FFF, 18'h2_A5C3);
    rd(14'h3FFF, 18'h2_A5C3, 1'h0);
    rd(14'h3FFF, 18'h2_A5C3, 1'h1);
  endtask : t_word
  task automatic t_lanes;
    wr(1'h1, 2'h0, 1'h0, 14'h0000, 18'h0_0000);
    wr(1'h1, 2'h1, 1'h0, 14'h0000, 18'h3_FFFF);
    rd(14'h0000, 18'h1_00FF, 1'h0);
    wr(1'h1, 2'h2, 1'h0, 14'h0000, 18'h2_AA55);
    rd(14'h0000, 18'h3_AAFF, 1'h0);
  endtask : t_lanes
  task automatic t_cancel;
    wr(1'h1, 2'h3, 1'h0, 14'h0000, 18'h0_1234);
    wr(1'h0, 2'h0, 1'h0, 14'h0000, 18'h0_1234);
    rd(14'h0000, 18'h3_AAFF, 1'h0);
  endtask : t_cancel
  task automatic t_latch;
    wr(1'h1, 2'h0, 1'h1, 14'h1555, 18'h1_5A5A);
    rd(14'h1555, 18'h1_5A5A, 1'h0);
  endtask : t_latch
  task automatic wrap_up;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (2) @(negedge mclk_i);
    chk(oe, '0);
    repeat (6) @(negedge mclk_i);
    srst_i = 1'h0;
    t_word();
    t_lanes();
    t_cancel();
    t_latch();
    wrap_up();
  end
endmodule : registered_input_sync_sram_test
